// [src/ccl_pkg.sv]
package ccl_pkg;

   // ---------------------------------------------------------------
   // Cache geometry
   // ---------------------------------------------------------------
   localparam int unsigned SEGMENTS      = 4;
   localparam int unsigned LINES_PER_SEG = 64;
   localparam int unsigned WORDS_PER_LN  = 4;
   localparam int unsigned SEG_BYTES     = 1024;
   localparam int unsigned SEG_W         = 2;
   localparam int unsigned IDX_W         = 6;
   localparam logic [5:0]  LAST_LINE     = 6'h3f;

   // ---------------------------------------------------------------
   // Address fields of a linefill request
   // ---------------------------------------------------------------
   localparam int unsigned SEG_LSB  = 4;
   localparam int unsigned LINE_LSB = 4;

   // ---------------------------------------------------------------
   // Register map, byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_DLOCKDOWN = 8'h00;
   localparam logic [7:0] OFS_ILOCKDOWN = 8'h04;
   localparam logic [7:0] OFS_IPREFETCH = 8'h08;
   localparam logic [7:0] OFS_STATUS    = 8'h0c;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam logic [31:0] LOCK_IDX_MASK   = 32'h0000_003f;
   localparam int unsigned LOCK_EN_BIT     = 31;
   localparam int unsigned ST_DVICT_LSB    = 0;
   localparam int unsigned ST_IVICT_LSB    = 8;
   localparam int unsigned ST_DLOCK_BIT    = 16;
   localparam int unsigned ST_ILOCK_BIT    = 17;
   localparam int unsigned ST_DBUSY_BIT    = 18;
   localparam int unsigned ST_IBUSY_BIT    = 19;
   localparam logic [31:0] LOCKDOWN_RST    = 32'h0000_0000;
   localparam logic [5:0]  VICTIM_RST      = 6'h00;
   localparam logic [31:0] PREFETCH_RST    = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [1:0] ccl_seg_of(input logic [31:0] addr);
      ccl_seg_of = addr[SEG_LSB +: SEG_W];
   endfunction

   function automatic logic [31:0] ccl_line_base(input logic [31:0] addr);
      ccl_line_base = {addr[31:LINE_LSB], 4'h0};
   endfunction

endpackage

// [src/ccl_lock_unit.sv]
// One cache's lockdown register, victim counter and linefill steering.
module ccl_lock_unit
   import ccl_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Lockdown register write
   input  wire logic        lock_we,
   input  wire logic [31:0] lock_wdata,
   // Miss from the core side
   input  wire logic        miss_valid,
   input  wire logic [31:0] miss_addr,
   output      logic        miss_ready,
   // Linefill toward external memory
   output      logic        fill_valid,
   input  wire logic        fill_ready,
   output      logic [31:0] fill_addr,
   output      logic [1:0]  fill_seg,
   output      logic [5:0]  fill_line,
   output      logic        fill_locked,
   // State for software
   output      logic        lock_en,
   output      logic [5:0]  lock_idx,
   output      logic [5:0]  victim
);

   logic        lock_en_r,  lock_en_nxt;
   logic [5:0]  lock_idx_r, lock_idx_nxt;
   logic [5:0]  floor_r,    floor_nxt;
   logic [5:0]  victim_r,   victim_nxt;
   logic        fvalid_r;
   logic [31:0] faddr_r;
   logic [1:0]  fseg_r;
   logic [5:0]  fline_r;
   logic        flock_r;

   wire         take_miss = miss_valid && miss_ready;
   wire         fill_done = fvalid_r && fill_ready;
   wire [5:0]   dest_line = lock_en_r ? lock_idx_r : victim_r;
   wire [5:0]   victim_wrap = (victim_r == LAST_LINE) ? floor_r : victim_r + 6'h01;

   // ------------------------------------------------------------
   // Lockdown register and victim range
   // ------------------------------------------------------------
   assign lock_en_nxt  = lock_we ? lock_wdata[LOCK_EN_BIT] : lock_en_r;
   assign lock_idx_nxt = lock_we ? lock_wdata[IDX_W-1:0] : lock_idx_r;
   // Clearing lock mode with index N fences off lines below N.
   assign floor_nxt    = (lock_we && !lock_wdata[LOCK_EN_BIT]) ? lock_wdata[IDX_W-1:0] : floor_r;

   // The victim only advances on unlocked fills and never drops below the floor.
   always_comb
   begin
      victim_nxt = victim_r;
      if (lock_we && !lock_wdata[LOCK_EN_BIT])
      begin
         victim_nxt = lock_wdata[IDX_W-1:0];
      end
      else if (take_miss && !lock_en_r)
      begin
         victim_nxt = victim_wrap;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         lock_en_r  <= 1'b0;
         lock_idx_r <= LOCKDOWN_RST[IDX_W-1:0];
         floor_r    <= VICTIM_RST;
         victim_r   <= VICTIM_RST;
      end
      else
      begin
         lock_en_r  <= lock_en_nxt;
         lock_idx_r <= lock_idx_nxt;
         floor_r    <= floor_nxt;
         victim_r   <= victim_nxt;
      end
   end

   // ------------------------------------------------------------
   // Linefill request, held until the memory side accepts it
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         fvalid_r <= 1'b0;
         faddr_r  <= 32'h0000_0000;
         fseg_r   <= 2'h0;
         fline_r  <= 6'h00;
         flock_r  <= 1'b0;
      end
      else if (take_miss)
      begin
         fvalid_r <= 1'b1;
         faddr_r  <= ccl_line_base(miss_addr);
         fseg_r   <= ccl_seg_of(miss_addr);
         fline_r  <= dest_line;
         flock_r  <= lock_en_r;
      end
      else if (fill_done)
      begin
         fvalid_r <= 1'b0;
      end
   end

   assign miss_ready  = !fvalid_r;
   assign fill_valid  = fvalid_r;
   assign fill_addr   = faddr_r;
   assign fill_seg    = fseg_r;
   assign fill_line   = fline_r;
   assign fill_locked = flock_r;
   assign lock_en     = lock_en_r;
   assign lock_idx    = lock_idx_r;
   assign victim      = victim_r;

endmodule // ccl_lock_unit

// [src/ccl_lockdown_ctrl.sv]
// Functional notes
// - Each cache has four segments of 64 four-word lines, 1KB each.
// - Locking works per line index across all four segments: 16 words.
// - Locked lines grow upward from zero; at most 63 of 64 lines locked.
// - Data and instruction caches each have their own lock bit and index.
// - Line index is the low six bits of the lockdown register.
// - Lock enable is bit 31 of the lockdown register.
// - In data lock mode a load miss fills the line at the lock index.
// - Each 16-byte address step selects the next segment, same line index.
// - Prefetch write drives the instruction address bus and forces an access.
// - Reading instruction lockdown register returns the current line index.
// - After lock clears with index N, victims stay within N to 63.
//
// The placing of the registers and the AHB-Lite register port were decided locally.
module ccl_lockdown_ctrl
   import ccl_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output      logic [31:0] hrdata,
   output      logic        hreadyout,
   output      logic        hresp,
   // Data side: load misses from the core
   input  wire logic        dmiss_valid,
   input  wire logic [31:0] dmiss_addr,
   output      logic        dmiss_ready,
   // Data linefill toward external memory
   output      logic        dfill_valid,
   input  wire logic        dfill_ready,
   output      logic [31:0] dfill_addr,
   output      logic [1:0]  dfill_seg,
   output      logic [5:0]  dfill_line,
   output      logic        dfill_locked,
   // Instruction address bus, forced by prefetch
   output      logic [31:0] iabus_addr,
   output      logic        iabus_force,
   // Instruction side: misses from the core
   input  wire logic        imiss_valid,
   input  wire logic [31:0] imiss_addr,
   output      logic        imiss_ready,
   // Instruction linefill toward external memory
   output      logic        ifill_valid,
   input  wire logic        ifill_ready,
   output      logic [31:0] ifill_addr,
   output      logic [1:0]  ifill_seg,
   output      logic [5:0]  ifill_line,
   output      logic        ifill_locked
);

   // ---------------------------------------------------------------
   // Geometry checks
   // ---------------------------------------------------------------
   // The index width and segment select must describe the cache exactly;
   // a mismatch here would silently alias lines.
   localparam int unsigned SEG_WORDS = LINES_PER_SEG * WORDS_PER_LN;
   localparam int unsigned CHK_BYTES = SEG_WORDS * 4;

   initial
   begin
      if (CHK_BYTES != SEG_BYTES || (1 << IDX_W) != LINES_PER_SEG || (1 << SEG_W) != SEGMENTS)
      begin
         $error("cache geometry constants are inconsistent");
      end
   end

   // ---------------------------------------------------------------
   // Bus address phase
   // ---------------------------------------------------------------
   logic        dph_valid_r;
   logic        dph_write_r;
   logic [7:0]  dph_addr_r;
   logic        rd_wait_r;
   logic [31:0] hrdata_r;

   // The address phase is only registered while the slave is ready, so a
   // read that is still waiting keeps its own offset and direction.
   wire         addr_take = hsel && htrans[1] && hready;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dph_valid_r <= 1'b0;
         dph_write_r <= 1'b0;
         dph_addr_r  <= 8'h00;
      end
      else if (hreadyout)
      begin
         dph_valid_r <= addr_take;
         dph_write_r <= hwrite;
         dph_addr_r  <= {haddr[7:2], 2'b00};
      end
   end

   // ---------------------------------------------------------------
   // Bus data phase decode
   // ---------------------------------------------------------------
   // Only address bits 7 to 2 are decoded, so the four registers repeat every
   // 256 bytes throughout the window that the system decoder gives this slave.
   function automatic logic reg_hit
   (
      input logic [7:0] a,
      input logic [7:0] ofs
   );
      return a == ofs;
   endfunction

   wire         wr_phase   = dph_valid_r && dph_write_r;
   wire         rd_phase   = dph_valid_r && !dph_write_r;
   wire         hit_dlock  = reg_hit(dph_addr_r, OFS_DLOCKDOWN);
   wire         hit_ilock  = reg_hit(dph_addr_r, OFS_ILOCKDOWN);
   wire         hit_ipref  = reg_hit(dph_addr_r, OFS_IPREFETCH);
   wire         hit_status = reg_hit(dph_addr_r, OFS_STATUS);

   // ---------------------------------------------------------------
   // Register write strobes
   // ---------------------------------------------------------------
   // Writes to the status word or to an unmapped offset are dropped
   // quietly, since a lockdown sequence never writes there.
   wire         dlock_we   = wr_phase && hit_dlock;
   wire         ilock_we   = wr_phase && hit_ilock;
   wire         ipref_we   = wr_phase && hit_ipref;

   // ---------------------------------------------------------------
   // Read wait state
   // ---------------------------------------------------------------
   // Reads take one wait state so that a write just before them is
   // already in the registers when the read data are sampled. The cost
   // is one cycle per read, which is harmless for a setup-time block.
   wire         rd_first   = rd_phase && !rd_wait_r;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_wait_r <= 1'b0;
      end
      else
      begin
         rd_wait_r <= rd_first;
      end
   end

   assign hreadyout = !rd_first;
   assign hresp     = 1'b0;

   // ---------------------------------------------------------------
   // Per-cache lockdown units
   // ---------------------------------------------------------------
   // The two caches are independent: each keeps its own lockdown word,
   // victim range and outstanding linefill.
   logic        d_lock_en;
   logic [5:0]  d_lock_idx;
   logic [5:0]  d_victim;
   logic        i_lock_en;
   logic [5:0]  i_lock_idx;
   logic [5:0]  i_victim;

   ccl_lock_unit u_dcache_lock
   (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .lock_we     (dlock_we),
      .lock_wdata  (hwdata),
      .miss_valid  (dmiss_valid),
      .miss_addr   (dmiss_addr),
      .miss_ready  (dmiss_ready),
      .fill_valid  (dfill_valid),
      .fill_ready  (dfill_ready),
      .fill_addr   (dfill_addr),
      .fill_seg    (dfill_seg),
      .fill_line   (dfill_line),
      .fill_locked (dfill_locked),
      .lock_en     (d_lock_en),
      .lock_idx    (d_lock_idx),
      .victim      (d_victim)
   );

   ccl_lock_unit u_instruction_cache_lock
   (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .lock_we     (ilock_we),
      .lock_wdata  (hwdata),
      .miss_valid  (imiss_valid),
      .miss_addr   (imiss_addr),
      .miss_ready  (imiss_ready),
      .fill_valid  (ifill_valid),
      .fill_ready  (ifill_ready),
      .fill_addr   (ifill_addr),
      .fill_seg    (ifill_seg),
      .fill_line   (ifill_line),
      .fill_locked (ifill_locked),
      .lock_en     (i_lock_en),
      .lock_idx    (i_lock_idx),
      .victim      (i_victim)
   );

   // ---------------------------------------------------------------
   // Instruction prefetch
   // ---------------------------------------------------------------
   // The forced access is a one-cycle pulse; the instruction cache
   // reports the resulting miss back on the miss port, which then
   // fills under the current instruction lock state.
   logic [31:0] iabus_addr_r;
   logic        iabus_force_r;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         iabus_addr_r  <= PREFETCH_RST;
         iabus_force_r <= 1'b0;
      end
      else
      begin
         iabus_force_r <= ipref_we;
         if (ipref_we)
         begin
            iabus_addr_r <= hwdata;
         end
      end
   end

   assign iabus_addr  = iabus_addr_r;
   assign iabus_force = iabus_force_r;

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   // Both lockdown registers share one layout, so software can add one to
   // the index it reads back and write the word straight back again.
   function automatic logic [31:0] lock_word
   (
      input logic       en,
      input logic [5:0] idx
   );
      logic [31:0] w;
      w              = LOCKDOWN_RST;
      w[LOCK_EN_BIT] = en;
      w[IDX_W-1:0]   = idx;
      return w;
   endfunction

   // The victim counters and fill flags are there for debugging only;
   // a lockdown sequence never needs them.
   function automatic logic [31:0] status_word
   (
      input logic [5:0] dvict,
      input logic [5:0] ivict,
      input logic       dlock,
      input logic       ilock,
      input logic       dbusy,
      input logic       ibusy
   );
      logic [31:0] w;
      w                        = 32'h0000_0000;
      w[ST_DVICT_LSB +: IDX_W] = dvict;
      w[ST_IVICT_LSB +: IDX_W] = ivict;
      w[ST_DLOCK_BIT]          = dlock;
      w[ST_ILOCK_BIT]          = ilock;
      w[ST_DBUSY_BIT]          = dbusy;
      w[ST_IBUSY_BIT]          = ibusy;
      return w;
   endfunction

   wire [31:0] dlock_rd  = lock_word(d_lock_en, d_lock_idx);
   wire [31:0] ilock_rd  = lock_word(i_lock_en, i_lock_idx);
   wire [31:0] status_rd = status_word(d_victim, i_victim, d_lock_en, i_lock_en, dfill_valid, ifill_valid);
   wire [31:0] rd_mux    = hit_dlock  ? dlock_rd  :
                           hit_ilock  ? ilock_rd  :
                           hit_ipref  ? iabus_addr_r :
                           hit_status ? status_rd : 32'h0000_0000;

   // Read data are taken in the stalled first cycle of a read and then
   // stand until the next read, so the bus always sees a settled value.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata_r <= 32'h0000_0000;
      end
      else if (rd_first)
      begin
         hrdata_r <= rd_mux;
      end
   end

   assign hrdata = hrdata_r;

endmodule // ccl_lockdown_ctrl

// [testbench/ccl_mem_model.sv]
// Memory side of one cache: accepts each linefill after a chosen delay.
module ccl_mem_model
(
   // Clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Linefill handshake
   input  wire logic       fill_valid,
   output      logic       fill_ready,
   // Cycles to stall before accepting
   input  wire logic [1:0] delay
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt_r;

   // Ready is a single-cycle pulse, so a stall never leaves it high.
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         fill_ready <= 1'b0;
         cnt_r      <= 2'h0;
      end
      else if (fill_valid && !fill_ready && cnt_r >= delay)
         fill_ready <= 1'b1;
      else
      begin
         fill_ready <= 1'b0;
         cnt_r      <= (fill_valid && !fill_ready) ? cnt_r + 2'h1 : 2'h0;
      end
endmodule // ccl_mem_model

// [testbench/ccl_lock_sva.sv]
module ccl_lock_sva
   import ccl_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Register bus
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   input  wire logic        hreadyout,
   // Data side
   input  wire logic        dmiss_valid,
   input  wire logic [31:0] dmiss_addr,
   input  wire logic        dmiss_ready,
   input  wire logic        dfill_valid,
   input  wire logic        dfill_ready,
   input  wire logic [31:0] dfill_addr,
   input  wire logic [1:0]  dfill_seg,
   input  wire logic [5:0]  dfill_line,
   input  wire logic        dfill_locked,
   // Instruction side
   input  wire logic        imiss_valid,
   input  wire logic [31:0] imiss_addr,
   input  wire logic        imiss_ready,
   input  wire logic        ifill_valid,
   input  wire logic [1:0]  ifill_seg,
   input  wire logic [31:0] iabus_addr,
   input  wire logic        iabus_force
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire rd_req = hsel && htrans[1] && hready && !hwrite;
   wire pf_req = hsel && htrans[1] && hready && hwrite && haddr[7:0] == OFS_IPREFETCH;
   wire d_acc  = dmiss_valid && dmiss_ready;
   wire i_acc  = imiss_valid && imiss_ready;

   property p_rd_wait;
      rd_req |=> !hreadyout ##1 hreadyout;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   property p_dfill;
      d_acc |=> dfill_valid && dfill_addr == ($past(dmiss_addr) & 32'hffff_fff0);
   endproperty
   a_dfill: assert property (p_dfill) else $error("data fill address wrong");
   property p_dseg;
      d_acc |=> dfill_seg == 2'($past(dmiss_addr) >> 4);
   endproperty
   a_dseg: assert property (p_dseg) else $error("data fill segment wrong");
   property p_iseg;
      i_acc |=> ifill_valid && ifill_seg == 2'($past(imiss_addr) >> 4);
   endproperty
   a_iseg: assert property (p_iseg) else $error("instr fill segment wrong");
   property p_dhold;
      dfill_valid && !dfill_ready |=> dfill_valid && $stable(dfill_line) && $stable(dfill_locked);
   endproperty
   a_dhold: assert property (p_dhold) else $error("fill line moved while stalled");
   property p_dstall;
      dfill_valid |-> !dmiss_ready;
   endproperty
   a_dstall: assert property (p_dstall) else $error("miss taken while fill pending");
   property p_drel;
      dfill_valid && dfill_ready |=> !dfill_valid && dmiss_ready;
   endproperty
   a_drel: assert property (p_drel) else $error("fill not released");
   property p_pref;
      pf_req |=> ##1 iabus_force && iabus_addr == $past(hwdata);
   endproperty
   a_pref: assert property (p_pref) else $error("prefetch not driven");
   property p_pulse;
      iabus_force |=> !iabus_force;
   endproperty
   a_pulse: assert property (p_pulse) else $error("prefetch pulse too long");
   c_lock: cover property (dfill_valid && dfill_ready && dfill_locked);
   c_rd: cover property (rd_req);
   c_pf: cover property (iabus_force);
endmodule // ccl_lock_sva

bind ccl_lockdown_ctrl ccl_lock_sva u_sva (.*);

// [testbench/testbench.sv]
module testbench
   import ccl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, iaf;
   logic [31:0] haddr, hwdata, hrdata, iab, pf;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        mv[2], mr[2], fv[2], fr[2], fk[2];
   logic [31:0] ma[2], fa[2];
   logic [1:0]  fs[2], dly[2];
   logic [5:0]  fl[2];
   logic [40:0] q[2][$];
   logic [40:0] e;
   logic [15:0] rs = 16'h0051;
   int          lk[2], ix[2], flo[2], vc[2];
   int          n_errors, total_checks, cyc;

   ccl_lockdown_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .dmiss_valid(mv[0]), .dmiss_addr(ma[0]), .dmiss_ready(mr[0]),
      .dfill_valid(fv[0]), .dfill_ready(fr[0]), .dfill_addr(fa[0]), .dfill_seg(fs[0]), .dfill_line(fl[0]),
      .dfill_locked(fk[0]), .iabus_addr(iab), .iabus_force(iaf), .imiss_valid(mv[1]), .imiss_addr(ma[1]),
      .imiss_ready(mr[1]), .ifill_valid(fv[1]), .ifill_ready(fr[1]), .ifill_addr(fa[1]), .ifill_seg(fs[1]),
      .ifill_line(fl[1]), .ifill_locked(fk[1]));
   ccl_mem_model u_dmem (.hclk(hclk), .hresetn(hresetn), .fill_valid(fv[0]), .fill_ready(fr[0]), .delay(dly[0]));
   ccl_mem_model u_imem (.hclk(hclk), .hresetn(hresetn), .fill_valid(fv[1]), .fill_ready(fr[1]), .delay(dly[1]));

   function automatic logic [31:0] rnd();
      rs = {rs[14:0], rs[15] ^ rs[13] ^ rs[12] ^ rs[10]};
      return {rs, rs ^ 16'ha5c3};
   endfunction

   function automatic logic [31:0] exp_reg(input logic [31:0] a);
      case (a)
         32'h0, 32'h4: return {lk[a[2]][0], 25'h0, ix[a[2]][5:0]};
         32'h8: return pf;
         32'hc: return {14'h0, lk[1][0], lk[0][0], 2'h0, vc[1][5:0], 2'h0, vc[0][5:0]};
         default: return 32'h0;
      endcase
   endfunction

   task automatic chk(input logic [31:0] x, input logic [31:0] g);
      total_checks++;
      if (g !== x)
      begin
         n_errors++;
         $display("wrong value at %0t: expected %h got %h", $time, x, g);
      end
   endtask

   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
      if (a < 8)
      begin
         lk[a[2]] = d[31];
         ix[a[2]] = d[5:0];
         if (!d[31])
         begin
            flo[a[2]] = d[5:0];
            vc[a[2]] = d[5:0];
         end
      end
      if (a == 8)
         pf = d;
   endtask

   task automatic rdc(input logic [31:0] a);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(exp_reg(a), r);
      chk(32'h0, {31'h0, hresp});
   endtask

   task automatic miss(input int c, input logic [31:0] a);
      @(posedge hclk);
      mv[c] <= 1'b1;
      ma[c] <= a;
      dly[c] <= 2'(rnd());
      do @(posedge hclk); while (mr[c] !== 1'b1);
      mv[c] <= 1'b0;
      q[c].push_back({lk[c][0], lk[c] ? ix[c][5:0] : vc[c][5:0], a[5:4], a & 32'hffff_fff0});
      if (!lk[c])
         vc[c] = (vc[c] == 63) ? flo[c] : vc[c] + 1;
   endtask

   task automatic drain();
      do @(negedge hclk); while (q[0].size() + q[1].size() != 0);
      repeat (2) @(posedge hclk);
   endtask

   task give_verdict();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(negedge hclk)
      for (int c = 0; c < 2; c++)
         if (fv[c] === 1'b1 && fr[c] === 1'b1)
         begin
            e = q[c].pop_front();
            chk(e[31:0], fa[c]);
            chk({23'h0, e[40:32]}, {23'h0, fk[c], fl[c], fs[c]});
         end

   // A hang anywhere ends in the closing report as a failure.
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_errors++;
         give_verdict();
      end
   end

   initial
   begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   initial
   begin
      logic [31:0] b;
      {hresetn, hsel, htrans, hwrite, haddr, hwdata, pf} = '0;
      hsize = 3'h2;
      mv = '{1'b0, 1'b0};
      ma = '{32'h0, 32'h0};
      dly = '{2'h0, 2'h0};
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      for (int a = 0; a < 20; a += 4)
         rdc(a);
      wr(32'h14, 32'hffff_ffff);
      rdc(32'h14);
      $display("test reset done");
      for (int l = 0; l < 2; l++)
      begin
         wr(0, 32'hffff_ff80 | l);
         rdc(0);
         b = rnd() & 32'hffff_ffc0;
         for (int s = 0; s < 4; s++)
            miss(0, b + 16 * s + (rnd() & 32'hf));
      end
      wr(0, 2);
      for (int n = 0; n < 5; n++)
         miss(0, rnd());
      drain();
      rdc(12);
      rdc(4);
      $display("test data lockdown done");
      wr(4, 32'h8000_0005);
      b = rnd() & 32'hffff_ffc0;
      for (int s = 0; s < 4; s++)
      begin
         wr(8, b + 16 * s);
         @(negedge hclk);
         chk(32'h1, {31'h0, iaf});
         chk(b + 16 * s, iab);
         miss(1, b + 16 * s);
      end
      drain();
      rdc(4);
      rdc(8);
      $display("test instr lockdown done");
      wr(4, 62);
      for (int n = 0; n < 3; n++)
         miss(1, rnd());
      wr(0, 63);
      miss(0, rnd());
      miss(0, rnd());
      drain();
      rdc(12);
      $display("test victim range done");
      give_verdict();
   end
endmodule // testbench
